// >>> mdsel_top.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "mdsel_cfg.svh"

//
// Summary of operation
// - eight main flash sector selects, each over one 16K sector
// - four boot flash segment selects, each over one 8K segment
// - upper-half main sectors match the page value; lower-half ones ignore it
// - control register block select spans 256 bytes, page independent
// - core-internal registers and RAM are outside external data space
// - boot flash segment beats main flash sector on overlap
// - sram, register block or peripheral select beats any flash select
// - each bus cycle grants exactly the highest-priority matching memory
// - lower memory hidden under higher select stays unreachable
// - software write moves either flash between data and program space
// - select equations come from the programmed non-volatile configuration
// - routing bits 4,3 gate data access, bits 2,1 gate fetch
// - reset reloads routing bits from the non-volatile default
module mdsel_top #(
  parameter int MAIN_N = `MDSEL_MAIN_N,
  parameter int BOOT_N = `MDSEL_BOOT_N
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire mdsel_pkg::mdsel_bus_t bus_i,
  output mdsel_pkg::mdsel_sel_t sel_o,
  input wire logic cfg_we_i,
  input wire logic [`MDSEL_CFG_AW-1:0] cfg_addr_i,
  input wire logic [`MDSEL_ENTRY_W-1:0] cfg_wdata_i,
  input wire mdsel_pkg::mdsel_apb_req_t apb_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o
);

  localparam int EW = `MDSEL_ENTRY_W;
  localparam int NE = `MDSEL_ENTRIES;

  logic [NE*EW-1:0] cfg_flat;
  logic [7:0] nv_route;
  logic data_cyc;
  logic fetch_cyc;
  logic [7:0] main_raw;
  logic [3:0] boot_raw;
  logic sram_raw;
  logic csr_raw;
  logic periph_raw;
  logic [2:0] top_pick;
  logic [3:0] boot_pick;
  logic [7:0] main_pick;
  mdsel_pkg::mdsel_sel_t sel;
  logic [7:0] route_q;
  logic [7:0] route_d;
  logic [14:0] status_q;
  logic [14:0] status_d;
  logic pready_q;
  logic pready_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;
  logic setup;
  logic done;
  logic hit_route;
  logic hit_status;
  logic aligned;
  logic main_page_ok;

  // select table held as the programmed configuration
  mdsel_cfg_mem #(
    .WIDTH(EW),
    .DEPTH(NE),
    .AW(`MDSEL_CFG_AW)
  ) u_cfg (
    .clock_i(clock_i),
    .we_i(cfg_we_i),
    .addr_i(cfg_addr_i),
    .wdata_i(cfg_wdata_i),
    .rdata_o(cfg_flat)
  );

  // pick one entry out of the flat table
  function automatic mdsel_pkg::mdsel_entry_t entry_at(
    input logic [NE*EW-1:0] flat,
    input int idx
  );
    entry_at = mdsel_pkg::mdsel_entry_t'(flat[idx*EW +: EW]);
  endfunction : entry_at

  // range compare with optional page qualifier
  function automatic logic range_hit(
    input mdsel_pkg::mdsel_entry_t e,
    input logic [15:0] addr,
    input logic [7:0] page,
    input logic qual
  );
    range_hit = e.en && (addr >= e.lo) && (addr <= e.hi) &&
                (!qual || (e.page == page));
  endfunction : range_hit

  // keep only the lowest set bit so at most one select wins
  function automatic logic [7:0] lowest(input logic [7:0] x);
    lowest = x & 8'(~x + 8'h01);
  endfunction : lowest

  assign nv_route = cfg_flat[`MDSEL_IDX_NVROUTE*EW +: 8];

  // raw matches of every select against the presented cycle
  always_comb begin
    mdsel_pkg::mdsel_entry_t e;
    e = '0;
    data_cyc = bus_i.rd | bus_i.wr;
    fetch_cyc = bus_i.fetch;
    for (int i = 0; i < MAIN_N; i++) begin
      e = entry_at(cfg_flat, `MDSEL_IDX_MAIN0 + i);
      main_raw[i] = range_hit(e, bus_i.addr, bus_i.page,
                              e.lo[`MDSEL_UPPER_BIT]) &&
                    ((data_cyc && route_q[`MDSEL_RT_MAIN_DATA]) ||
                     (fetch_cyc && route_q[`MDSEL_RT_MAIN_FETCH]));
    end
    for (int i = 0; i < BOOT_N; i++) begin
      e = entry_at(cfg_flat, `MDSEL_IDX_BOOT0 + i);
      boot_raw[i] = range_hit(e, bus_i.addr, bus_i.page, 1'b0) &&
                    ((data_cyc && route_q[`MDSEL_RT_BOOT_DATA]) ||
                     (fetch_cyc && route_q[`MDSEL_RT_BOOT_FETCH]));
    end
    // sram, register block and peripheral live only in data space
    e = entry_at(cfg_flat, `MDSEL_IDX_SRAM);
    sram_raw = data_cyc && range_hit(e, bus_i.addr, bus_i.page, e.use_page);
    e = entry_at(cfg_flat, `MDSEL_IDX_CSR);
    csr_raw = data_cyc && e.en &&
              (bus_i.addr[`MDSEL_CSR_PAGE_HI:`MDSEL_CSR_PAGE_LO] ==
               e.lo[`MDSEL_CSR_PAGE_HI:`MDSEL_CSR_PAGE_LO]);
    e = entry_at(cfg_flat, `MDSEL_IDX_PERIPH);
    periph_raw = data_cyc && route_q[`MDSEL_RT_PIO] &&
                 range_hit(e, bus_i.addr, bus_i.page, e.use_page);
  end

  // priority: top level over boot flash over main flash
  // only external cycles reach here, so core-internal space never collides
  always_comb begin
    logic [7:0] t;
    logic [7:0] b;
    t = lowest({5'h00, periph_raw, csr_raw, sram_raw});
    b = lowest({4'h0, boot_raw});
    top_pick = t[2:0];
    boot_pick = (|top_pick) ? 4'h0 : b[3:0];
    main_pick = ((|top_pick) || (|boot_raw)) ? 8'h00 :
                lowest(main_raw);
    sel.sram = top_pick[0];
    sel.csr = top_pick[1];
    sel.periph = top_pick[2];
    sel.boot = boot_pick;
    sel.main = main_pick;
  end

  // selects leave without a register so the cycle sees them at once
  assign sel_o = sel;

  // apb decode of the current request
  always_comb begin
    setup = apb_i.psel && !apb_i.penable;
    done = apb_i.psel && apb_i.penable && pready_q;
    aligned = (apb_i.paddr[1:0] == 2'b00);
    hit_route = apb_i.paddr == `MDSEL_ROUTE_ADDR;
    hit_status = apb_i.paddr == `MDSEL_STATUS_ADDR;
  end

  // next values of routing, status and apb answer
  always_comb begin
    route_d = route_q;
    status_d = status_q;
    pready_d = 1'b0;
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (done && apb_i.pwrite && hit_route) begin
      route_d = apb_i.pwdata[7:0] & `MDSEL_RT_MASK;
    end
    if (data_cyc || fetch_cyc) begin
      status_d = sel;
    end
    if (setup) begin
      pready_d = 1'b1;
      pslverr_d = !(aligned && (hit_route || hit_status));
      if (!apb_i.pwrite && hit_route) begin
        prdata_d = {24'h00_0000, route_q};
      end else if (!apb_i.pwrite && hit_status) begin
        prdata_d = {17'h0_0000, status_q};
      end
    end
    if (reset_i) begin
      route_d = nv_route & `MDSEL_RT_NV_MASK;
      status_d = 15'h0000;
      pready_d = 1'b0;
      prdata_d = 32'h0000_0000;
      pslverr_d = 1'b0;
    end
  end

  // register stage
  always_ff @(posedge clock_i) begin
    route_q <= route_d;
    status_q <= status_d;
    pready_q <= pready_d;
    prdata_q <= prdata_d;
    pslverr_q <= pslverr_d;
  end

  assign pready_o = pready_q;
  assign prdata_o = prdata_q;
  assign pslverr_o = pslverr_q;

  // page of each granted upper-half main sector against the bus page
  always_comb begin
    mdsel_pkg::mdsel_entry_t m;
    m = '0;
    main_page_ok = 1'b1;
    for (int i = 0; i < MAIN_N; i++) begin
      m = entry_at(cfg_flat, `MDSEL_IDX_MAIN0 + i);
      if (sel.main[i] && m.lo[`MDSEL_UPPER_BIT] &&
          (m.page != bus_i.page)) begin
        main_page_ok = 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);

  sequence route_write_s;
    done && apb_i.pwrite && hit_route;
  endsequence

  sequence apb_setup_s;
    apb_i.psel && !apb_i.penable;
  endsequence

  top_over_flash_a: assert property (
    (sel.sram || sel.csr || sel.periph) |-> (sel.main == 8'h00) &&
    (sel.boot == 4'h0))
    else $error("flash select active under top-level select");

  boot_over_main_a: assert property (
    (|boot_raw && !(|top_pick)) |-> (sel.main == 8'h00) && (|sel.boot))
    else $error("main select not yielding to boot select");

  single_grant_a: assert property (
    $onehot0(sel) && ((|main_raw || |boot_raw || sram_raw || csr_raw ||
    periph_raw) == (|sel)))
    else $error("grant is not exactly one matching select");

  csr_span_a: assert property (
    sel.csr |-> bus_i.addr[15:8] ==
    cfg_flat[`MDSEL_IDX_CSR*EW + 24 +: 8])
    else $error("register block select outside its 256 byte window");

  fetch_gate_a: assert property (
    (fetch_cyc && !data_cyc && !route_q[`MDSEL_RT_MAIN_FETCH]) |->
    (sel.main == 8'h00) && !sel.sram && !sel.csr)
    else $error("fetch reached main flash or data-only memory");

  route_reset_a: assert property (
    $fell(reset_i) |-> route_q == ($past(nv_route) & `MDSEL_RT_NV_MASK))
    else $error("routing register not reloaded from default");

  route_write_a: assert property (
    route_write_s |=> route_q == ($past(apb_i.pwdata[7:0]) &
    `MDSEL_RT_MASK))
    else $error("routing write not taken");

  idle_no_select_a: assert property (
    !(bus_i.rd || bus_i.wr || bus_i.fetch) |-> sel == '0)
    else $error("select active with no strobe");

  apb_ready_a: assert property (
    apb_setup_s |=> pready_o ##1 !pready_o)
    else $error("apb answer not given in the access cycle");

  upper_page_a: assert property (
    (|sel.main) |-> main_page_ok)
    else $error("upper main sector granted without a page match");

  // unmapped or unaligned requests get an error and no data
  apb_refuse_a: assert property (
    (apb_i.psel && !apb_i.penable && !(aligned && (hit_route || hit_status)))
    |=> pslverr_o && (prdata_o == 32'h0000_0000))
    else $error("unmapped apb request not refused");

  // status follows the select granted on every strobed cycle
  status_capture_a: assert property (
    (bus_i.rd || bus_i.wr || bus_i.fetch) |=> status_q == $past(sel))
    else $error("status did not capture the granted select");

  // routing only moves on a register write or a reset
  route_hold_a: assert property (
    !(done && apb_i.pwrite && hit_route) |=> $stable(route_q))
    else $error("routing register changed without a write");

  // peripheral mode always comes out of reset disabled
  pio_reset_a: assert property (
    $fell(reset_i) |-> !route_q[`MDSEL_RT_PIO])
    else $error("peripheral mode left on after reset");

endmodule : mdsel_top

// >>> mdsel_cfg.svh
`ifndef MDSEL_CFG_SVH
`define MDSEL_CFG_SVH

// select table layout
`define MDSEL_MAIN_N 8
`define MDSEL_BOOT_N 4
`define MDSEL_ENTRIES 16
`define MDSEL_CFG_AW 4
`define MDSEL_ENTRY_W 42
`define MDSEL_IDX_MAIN0 0
`define MDSEL_IDX_BOOT0 8
`define MDSEL_IDX_SRAM 12
`define MDSEL_IDX_CSR 13
`define MDSEL_IDX_PERIPH 14
`define MDSEL_IDX_NVROUTE 15

// address field positions
`define MDSEL_UPPER_BIT 15
`define MDSEL_CSR_PAGE_HI 15
`define MDSEL_CSR_PAGE_LO 8

// register indices and byte addresses on the apb side
`define MDSEL_APB_AW 12
`define MDSEL_ROUTE_IDX 10'h0e2
`define MDSEL_ROUTE_ADDR {`MDSEL_ROUTE_IDX, 2'b00}
`define MDSEL_STATUS_ADDR 12'h000

// space routing register bits
`define MDSEL_RT_PIO 7
`define MDSEL_RT_MAIN_DATA 4
`define MDSEL_RT_BOOT_DATA 3
`define MDSEL_RT_MAIN_FETCH 2
`define MDSEL_RT_BOOT_FETCH 1
`define MDSEL_RT_MASK 8'h9e
`define MDSEL_RT_NV_MASK 8'h1e

`endif

// >>> mdsel_pkg.sv
package mdsel_pkg;

  // one range entry of the decode logic array
  typedef struct packed {
    logic en;
    logic use_page;
    logic [7:0] page;
    logic [15:0] lo;
    logic [15:0] hi;
  } mdsel_entry_t;

  // one microcontroller bus cycle
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] page;
    logic rd;
    logic wr;
    logic fetch;
  } mdsel_bus_t;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mdsel_apb_req_t;

  // all memory selects
  typedef struct packed {
    logic periph;
    logic csr;
    logic sram;
    logic [3:0] boot;
    logic [7:0] main;
  } mdsel_sel_t;

endpackage : mdsel_pkg

// >>> mdsel_cfg_mem.sv
`timescale 1ns/1ps

// configuration store, written over the test port, read in parallel
module mdsel_cfg_mem #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clock_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [DEPTH*WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];

  // next contents: only the addressed word changes
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
      if (we_i && (int'(addr_i) == i)) begin
        mem_d[i] = wdata_i;
      end
    end
  end

  // no reset: contents stand for the programmed configuration
  always_ff @(posedge clock_i) begin
    mem_q <= mem_d;
  end

  // parallel read straight from the storage flops
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      rdata_o[i*WIDTH +: WIDTH] = mem_q[i];
    end
  end

endmodule : mdsel_cfg_mem

// >>> mdsel_mcu_model.sv
`timescale 1ns/1ps

// microcontroller side of the external bus, one cycle per request
module mdsel_mcu_model (
  input wire logic clock_i,
  input wire logic [1:0] kind_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] page_i,
  output mdsel_pkg::mdsel_bus_t bus_o
);
  initial bus_o = '0;

  // kind 1 read, 2 write, 3 fetch; idle lets address and page wander
  always @(posedge clock_i) begin
    bus_o.rd <= (kind_i == 2'd1);
    bus_o.wr <= (kind_i == 2'd2);
    bus_o.fetch <= (kind_i == 2'd3);
    if (kind_i == 2'd0) begin
      bus_o.addr <= ~bus_o.addr;
      bus_o.page <= ~bus_o.page;
    end else begin
      bus_o.addr <= addr_i;
      bus_o.page <= page_i;
    end
  end
endmodule : mdsel_mcu_model

// >>> memory_select_decoder_test.sv
`timescale 1ns/1ps
`include "mdsel_cfg.svh"

module memory_select_decoder_test;
  logic clock_i;
  logic reset_i;
  logic cfg_we_q;
  logic [3:0] cfg_addr_q;
  logic [41:0] cfg_data_q;
  logic [1:0] kind_q;
  logic [15:0] addr_q;
  logic [7:0] page_q;
  logic [31:0] rd;
  logic er;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  int err_total;
  int checks_done;
  mdsel_pkg::mdsel_bus_t bus;
  mdsel_pkg::mdsel_sel_t sel;
  mdsel_pkg::mdsel_apb_req_t apb_q;

  mdsel_mcu_model mcu (.clock_i(clock_i), .kind_i(kind_q),
    .addr_i(addr_q), .page_i(page_q), .bus_o(bus));

  mdsel_top dut (.clock_i(clock_i), .reset_i(reset_i), .bus_i(bus),
    .sel_o(sel), .cfg_we_i(cfg_we_q), .cfg_addr_i(cfg_addr_q),
    .cfg_wdata_i(cfg_data_q), .apb_i(apb_q), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr));

  // 4 ns clock
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  // map entries: legal sizes, no same-level overlap
  function automatic logic [41:0] entry(input int i);
    logic [15:0] lo;
    lo = 16'(16'h2000 * (i - 8)) + 16'h8000;
    if (i < 2) begin
      lo = 16'(16'h4000 * i);
    end else if (i < 8) begin
      lo = 16'(16'h4000 * (i % 2)) + 16'h8000;
    end
    case (i)
      0, 1, 2, 3, 4, 5, 6, 7: return {1'b1, i >= 2, 8'(i / 2 - 1), lo,
                                      lo + 16'h3fff};
      8, 9, 10, 11: return {2'b10, 8'h00, lo, lo + 16'h1fff};
      12: return {2'b10, 8'h00, 16'h8000, 16'h87ff};
      13: return {2'b10, 8'h00, 16'h2000, 16'h20ff};
      14: return {2'b10, 8'h00, 16'h3000, 16'h30ff};
      default: return {2'b00, 8'h00, 16'h0000, 16'h000c};
    endcase
  endfunction : entry

  // one bus cycle; selects looked at once the model has launched it
  task automatic cyc(input logic [1:0] k, input logic [15:0] a,
                     input logic [7:0] p, input logic [14:0] x);
    @(posedge clock_i);
    kind_q <= k;
    addr_q <= a;
    page_q <= p;
    @(posedge clock_i);
    #1 chk("sel", 32'(sel), 32'(x));
  endtask : cyc

  // apb transfer, request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    apb_q <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock_i);
    apb_q.penable <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    er = pslverr;
    apb_q.psel <= 1'b0;
    apb_q.penable <= 1'b0;
    if (n >= 64) begin
      err_total++;
      tally_and_finish();
    end
  endtask : apb

  task automatic rreg(input logic [11:0] a, input logic [31:0] x,
                      input logic xe);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", rd, x);
    chk("pslverr", 32'(er), 32'(xe));
  endtask : rreg

  // reset with table load, then the scenarios
  initial begin
    err_total = 0;
    checks_done = 0;
    reset_i = 1'b1;
    cfg_we_q = 1'b0;
    cfg_addr_q = 4'h0;
    cfg_data_q = '0;
    kind_q = 2'd0;
    addr_q = 16'h0000;
    page_q = 8'h00;
    apb_q = '0;
    @(posedge clock_i);
    for (int i = 0; i < 16; i++) begin
      cfg_we_q <= 1'b1;
      cfg_addr_q <= 4'(i);
      cfg_data_q <= entry(i);
      @(posedge clock_i);
    end
    cfg_we_q <= 1'b0;
    repeat (3) @(posedge clock_i);
    reset_i <= 1'b0;
    rreg(`MDSEL_ROUTE_ADDR, 32'h0000_000c, 1'b0);
    cyc(2'd3, 16'h0000, 8'h07, 15'h0001);
    cyc(2'd3, 16'h7fff, 8'h03, 15'h0002);
    cyc(2'd3, 16'h8800, 8'h01, 15'h0010);
    cyc(2'd3, 16'hffff, 8'h02, 15'h0080);
    cyc(2'd3, 16'h8800, 8'h03, 15'h0000);
    cyc(2'd3, 16'h9000, 8'h00, 15'h0004);
    cyc(2'd1, 16'h9000, 8'h00, 15'h0100);
    cyc(2'd1, 16'he000, 8'h00, 15'h0800);
    cyc(2'd1, 16'hdfff, 8'h00, 15'h0400);
    cyc(2'd2, 16'h20ff, 8'h05, 15'h2000);
    cyc(2'd1, 16'h2100, 8'h00, 15'h0000);
    cyc(2'd1, 16'h3000, 8'h00, 15'h0000);
    cyc(2'd1, 16'h8100, 8'h00, 15'h1000);
    cyc(2'd0, 16'h8100, 8'h00, 15'h0000);
    rreg(`MDSEL_STATUS_ADDR, 32'h0000_1000, 1'b0);
    apb(1'b1, `MDSEL_ROUTE_ADDR, 32'h0000_009e);
    rreg(`MDSEL_ROUTE_ADDR, 32'h0000_009e, 1'b0);
    cyc(2'd1, 16'h3000, 8'h00, 15'h4000);
    cyc(2'd1, 16'h9000, 8'h00, 15'h0100);
    cyc(2'd3, 16'ha000, 8'h01, 15'h0200);
    apb(1'b1, `MDSEL_ROUTE_ADDR, 32'h0000_0010);
    cyc(2'd1, 16'h9000, 8'h00, 15'h0004);
    cyc(2'd3, 16'h0000, 8'h00, 15'h0000);
    cyc(2'd0, 16'h0000, 8'h00, 15'h0000);
    rreg(12'h004, 32'h0000_0000, 1'b1);
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    rreg(`MDSEL_ROUTE_ADDR, 32'h0000_000c, 1'b0);
    tally_and_finish();
  end
endmodule : memory_select_decoder_test
